// ### rtl/ddc_pkg.sv
// Function
// - NCOs synchronize at link initialization or on SYSREF, chosen by two control bits.
// - With sync-on-link-init and link enable set, a SYNC rising edge (source chosen by use_timestamp_sync) is the sync event.
// - Software drops link enable, programs words; receiver holds SYNC high then pulls low.
// - Writing sync-on-next-SYSREF from 0 to 1 arms one sync on the next SYSREF event.
// - Once armed, NCOs synchronize on the first SYSREF rising edge after arming.
// - Decimation factor is 2, 4, 8 or 16; output rate is clock over factor. The code also has DEC_NONE, a bypass with no decimation.
// - Filter outputs are 15 bits; by-2 is real, by-4, by-8, by-16 are complex.
// - Stages cascade by mode; by-4 uses narrow or wide stage before the final one.
// - Every stage uses symmetric coefficients around one center tap.
// - Frequency words are 32 bits; NCO frequency is word times 2^-32 times clock.
package ddc_pkg;
  localparam int ADC_W = 12;
  localparam int OUT_W = 15;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_STAGES = 5;
  localparam logic [FREQ_W-1:0] NCO_RESET = 32'h0;
  // Stage order: first, second, third, by-4 (narrow or wide), final.
  localparam logic [NUM_STAGES-1:0] MASK_NONE = 5'h00;
  localparam logic [NUM_STAGES-1:0] MASK_D2 = 5'h10;
  localparam logic [NUM_STAGES-1:0] MASK_D4 = 5'h18;
  localparam logic [NUM_STAGES-1:0] MASK_D8 = 5'h16;
  localparam logic [NUM_STAGES-1:0] MASK_D16 = 5'h17;
  localparam int BY4_STAGE = 3;
  localparam logic signed [3:0] CENTER_NARROW = 4'sh2;
  localparam logic signed [3:0] CENTER_WIDE = 4'sh6;
  localparam int SHIFT_NARROW = 2;
  localparam int SHIFT_WIDE = 3;

  typedef enum logic [2:0] {DEC_NONE, DEC_2, DEC_4, DEC_8, DEC_16} ddc_decim_e;

  typedef struct packed {
    logic signed [OUT_W-1:0] i;
    logic signed [OUT_W-1:0] q;
  } ddc_sample_s;

  typedef struct packed {
    logic cplx;
    ddc_sample_s smp;
  } ddc_out_s;
endpackage

// ### rtl/ddc_nco_sync_decim.sv
`timescale 1ns/10ps
module ddc_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes the buffer while low.
  input wire logic [WIDTH-1:0] in_data, // Word to store.
  input wire logic in_valid, // Word present.
  output logic in_ready, // Room for a word.
  output logic [WIDTH-1:0] out_data, // Oldest word.
  output logic out_valid, // Buffer not empty.
  input wire logic out_ready // Sink takes the word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = clk_en && in_valid && in_ready;
    pop = clk_en && out_valid && out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

module ddc_nco_sync_decim (
  input wire logic sys_clk, // Device sampling clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic sync_on_link_init, // Sync NCOs on SYNC release.
  input wire logic sync_on_next_sysref, // Rising value arms one SYSREF sync.
  input wire logic serial_link_enable, // Link enable.
  input wire logic use_timestamp_sync, // Take SYNC from timestamp input.
  input wire logic single_ended_sync_in, // SYNC pin, asynchronous.
  input wire logic timestamp_diff_in, // Alternate SYNC pin, asynchronous.
  input wire logic sysref_in, // SYSREF pin, asynchronous.
  input wire logic [ddc_pkg::FREQ_W-1:0] chan_a_freq_word, // Channel A frequency.
  input wire logic [ddc_pkg::FREQ_W-1:0] chan_b_freq_word, // Channel B frequency.
  input wire logic [ddc_pkg::PHASE_W-1:0] chan_a_phase_offset, // Channel A phase.
  input wire logic [ddc_pkg::PHASE_W-1:0] chan_b_phase_offset, // Channel B phase.
  input wire ddc_pkg::ddc_decim_e decim_mode, // Decimation setting.
  input wire logic wide_passband_by4, // Wide stage in by-4 mode.
  input wire logic signed [ddc_pkg::ADC_W-1:0] adc_data, // Converter sample.
  input wire logic adc_valid, // Sample present.
  output logic adc_ready, // Path accepts a sample.
  output logic [ddc_pkg::FREQ_W-1:0] nco_a_phase, // Channel A accumulator.
  output logic [ddc_pkg::FREQ_W-1:0] nco_b_phase, // Channel B accumulator.
  output logic sync_armed, // SYSREF sync armed.
  output ddc_pkg::ddc_out_s out_data, // Output sample.
  output logic out_valid, // Output sample present.
  input wire logic out_ready // Sink takes the sample.
);
  import ddc_pkg::*;

  // ****************************************************************
  // Pin synchronizers and sync events.
  // ****************************************************************
  logic [1:0] se_sync, ts_sync, sref_sync;
  logic sync_prev, sref_prev, arm_prev, next_armed;
  logic sync_lvl, link_evt, sref_evt, arm_rise, sync_evt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      se_sync <= 2'h3;
      ts_sync <= 2'h3;
      sref_sync <= 2'h0;
    end else if (clk_en) begin
      se_sync <= {se_sync[0], single_ended_sync_in};
      ts_sync <= {ts_sync[0], timestamp_diff_in};
      sref_sync <= {sref_sync[0], sysref_in};
    end
  end

  always_comb begin
    sync_lvl = use_timestamp_sync ? ts_sync[1] : se_sync[1];
    link_evt = clk_en && sync_on_link_init && serial_link_enable
      && sync_lvl && !sync_prev;
    sref_evt = clk_en && sync_armed && sref_sync[1] && !sref_prev;
    arm_rise = clk_en && sync_on_next_sysref && !arm_prev;
    sync_evt = link_evt || sref_evt;
    // A new arming wins over the disarm of a firing edge.
    next_armed = arm_rise ? 1'b1 : (sref_evt ? 1'b0 : sync_armed);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev <= 1'b1;
      sref_prev <= 1'b0;
      arm_prev <= 1'b0;
      sync_armed <= 1'b0;
    end else if (clk_en) begin
      sync_prev <= sync_lvl;
      sref_prev <= sref_sync[1];
      arm_prev <= sync_on_next_sysref;
      sync_armed <= next_armed;
    end
  end

  // ****************************************************************
  // Phase accumulators.
  // ****************************************************************
  logic [FREQ_W-1:0] next_nco_a, next_nco_b;

  always_comb begin
    next_nco_a = nco_a_phase + chan_a_freq_word;
    next_nco_b = nco_b_phase + chan_b_freq_word;
    if (sync_evt) begin
      next_nco_a = {chan_a_phase_offset, 16'h0000};
      next_nco_b = {chan_b_phase_offset, 16'h0000};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nco_a_phase <= NCO_RESET;
      nco_b_phase <= NCO_RESET;
    end else if (clk_en) begin
      nco_a_phase <= next_nco_a;
      nco_b_phase <= next_nco_b;
    end
  end

  // ****************************************************************
  // Coarse quadrant mixer and stage selection.
  // ****************************************************************
  logic fifo_in_ready, adv, cplx;
  logic [NUM_STAGES-1:0] stage_en;
  logic signed [OUT_W-1:0] x_ext;
  ddc_sample_s mixed;

  always_comb begin
    adv = clk_en && fifo_in_ready;
    adc_ready = adv;
    x_ext = OUT_W'(adc_data);
    case (decim_mode)
      DEC_2: stage_en = MASK_D2;
      DEC_4: stage_en = MASK_D4;
      DEC_8: stage_en = MASK_D8;
      DEC_16: stage_en = MASK_D16;
      default: stage_en = MASK_NONE;
    endcase
    cplx = !(decim_mode == DEC_NONE || decim_mode == DEC_2);
    mixed.i = x_ext;
    mixed.q = '0;
    if (cplx) begin
      case (nco_a_phase[31:30])
        2'h1: begin
          mixed.i = '0;
          mixed.q = x_ext;
        end
        2'h2: mixed.i = -x_ext;
        2'h3: begin
          mixed.i = '0;
          mixed.q = -x_ext;
        end
        default: mixed.i = x_ext;
      endcase
    end
  end

  // ****************************************************************
  // Half-rate symmetric filter stages.
  // ****************************************************************
  ddc_sample_s st_in [NUM_STAGES+1];
  logic st_v [NUM_STAGES+1];

  assign st_in[0] = mixed;
  assign st_v[0] = adc_valid;

  genvar k;
  generate
    for (k = 0; k < NUM_STAGES; k++) begin : g_stage
      ddc_sample_s d1, d2, res, next_d1, next_d2, next_res;
      logic ph, vld, next_ph, next_vld, wide;
      logic signed [OUT_W+4:0] acc_i, acc_q;

      always_comb begin
        wide = (k == BY4_STAGE) && wide_passband_by4;
        // Taps 1, c, 1 around one center tap.
        acc_i = (OUT_W+5)'(st_in[k].i) + (OUT_W+5)'(d2.i)
              + (wide ? CENTER_WIDE : CENTER_NARROW) * (OUT_W+5)'(d1.i);
        acc_q = (OUT_W+5)'(st_in[k].q) + (OUT_W+5)'(d2.q)
              + (wide ? CENTER_WIDE : CENTER_NARROW) * (OUT_W+5)'(d1.q);
        next_d1 = d1;
        next_d2 = d2;
        next_ph = ph;
        next_vld = vld;
        next_res = res;
        if (adv) begin
          next_vld = st_v[k] && ph;
          if (st_v[k]) begin
            next_d1 = st_in[k];
            next_d2 = d1;
            next_ph = !ph;
            next_res.i = OUT_W'(acc_i >>> (wide ? SHIFT_WIDE : SHIFT_NARROW));
            next_res.q = OUT_W'(acc_q >>> (wide ? SHIFT_WIDE : SHIFT_NARROW));
          end
        end
      end

      assign st_in[k+1] = stage_en[k] ? res : st_in[k];
      assign st_v[k+1] = stage_en[k] ? vld : st_v[k];
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          d1 <= '0;
          d2 <= '0;
          res <= '0;
          ph <= 1'b0;
          vld <= 1'b0;
        end else begin
          d1 <= next_d1;
          d2 <= next_d2;
          res <= next_res;
          ph <= next_ph;
          vld <= next_vld;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Output buffer.
  // ****************************************************************
  ddc_out_s push_data;
  logic push_valid;

  always_comb begin
    push_data.cplx = cplx;
    push_data.smp.i = st_in[NUM_STAGES].i;
    push_data.smp.q = cplx ? st_in[NUM_STAGES].q : '0;
    push_valid = adv && st_v[NUM_STAGES];
  end

  ddc_fifo #(.WIDTH($bits(ddc_out_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_data(push_data),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_link_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_evt |=> nco_a_phase == {$past(chan_a_phase_offset), 16'h0000})
    else $error("SYNC release did not reload channel A");
  chk_both_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sync_evt |=> nco_b_phase == {$past(chan_b_phase_offset), 16'h0000})
    else $error("Sync event did not reload channel B");
  chk_arm_on_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(sync_on_next_sysref) && clk_en && $past(clk_en) |=> sync_armed)
    else $error("Arming write did not arm");
  chk_sysref_disarm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sref_evt && !arm_rise |=> !sync_armed ##0 nco_a_phase[15:0] == 16'h0000)
    else $error("SYSREF sync did not disarm and reload");
  chk_nco_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !sync_evt |=> nco_a_phase == $past(nco_a_phase) + $past(chan_a_freq_word))
    else $error("Accumulator did not advance by the frequency word");
  chk_unarmed_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !sync_armed && !link_evt |=>
      nco_b_phase == $past(nco_b_phase) + $past(chan_b_freq_word))
    else $error("Accumulator reloaded without an event");
  chk_bypass_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adv && adc_valid && decim_mode == DEC_NONE |-> push_valid && push_data.smp.i == x_ext)
    else $error("Bypass did not pass the sample");
  chk_real_by2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push_valid && decim_mode == DEC_2 |-> !push_data.cplx && push_data.smp.q == '0)
    else $error("By-2 output not real");
  chk_full_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fifo_in_ready |-> !adc_ready && !push_valid)
    else $error("Full buffer did not stall the path");
endmodule

// ### testbench/ddc_link_partner.sv
`timescale 1ns/10ps
module ddc_link_partner (
  input wire logic sys_clk, // Device clock.
  input wire logic use_ts, // Selects which pin carries the link SYNC.
  output logic sync_se, // Single-ended SYNC line.
  output logic sync_ts, // Timestamp SYNC line.
  output logic sysref // SYSREF line.
);
  logic sync_lvl = 1'b1;
  logic junk = 1'b0;
  initial sysref = 1'b0;
  // The unselected SYNC pin toggles so that a wrong pin choice shows up.
  always @(posedge sys_clk) junk <= ~junk;
  always_comb begin
    sync_se = use_ts ? junk : sync_lvl;
    sync_ts = use_ts ? sync_lvl : junk;
  end
  task automatic set_sync(input logic v);
    @(posedge sys_clk);
    #1 sync_lvl = v;
  endtask
  // Pulses keep one fixed phase to the clock, then SYSREF rests low.
  task automatic pulse_sysref(input int w);
    @(posedge sys_clk);
    #1 sysref = 1'b1;
    repeat (w) @(posedge sys_clk);
    #1 sysref = 1'b0;
  endtask
endmodule

// ### testbench/ddc_nco_sync_decimation_tb_top.sv
`timescale 1ns/10ps
module ddc_nco_sync_decimation_tb_top;
  import ddc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, sync_on_link_init = 1'b0;
  logic sync_on_next_sysref = 1'b0, serial_link_enable = 1'b0, use_timestamp_sync = 1'b0;
  logic se_in, ts_in, sr_in, wide_passband_by4 = 1'b0, adc_valid = 1'b0, out_ready = 1'b0;
  logic [FREQ_W-1:0] chan_a_freq_word = '0, chan_b_freq_word = '0, nco_a_phase, nco_b_phase;
  logic [FREQ_W-1:0] p0, p1;
  logic [PHASE_W-1:0] chan_a_phase_offset = '0, chan_b_phase_offset = '0;
  ddc_decim_e decim_mode = DEC_NONE;
  logic signed [ADC_W-1:0] adc_data = '0, h1 = '0, h2 = '0;
  logic signed [OUT_W-1:0] v;
  logic signed [OUT_W+4:0] fsum;
  logic adc_ready, sync_armed, out_valid, hold_off = 1'b0, rnd_on = 1'b0, f;
  ddc_out_s out_data, e;
  ddc_out_s exp_q[$];
  logic full_q[$];
  int err_total = 0, n_checks = 0, seed = 32'hd48d;
  ddc_decim_e modes[6] = '{DEC_NONE, DEC_2, DEC_4, DEC_4, DEC_8, DEC_16};
  int fac[6] = '{1, 2, 4, 4, 8, 16};
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    out_ready <= #1 hold_off ? 1'b0 : (rnd_on ? 1'($random(seed)) : 1'b1);

  ddc_nco_sync_decim ddc_nco_sync_decim_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sync_on_link_init(sync_on_link_init), .sync_on_next_sysref(sync_on_next_sysref),
    .serial_link_enable(serial_link_enable), .use_timestamp_sync(use_timestamp_sync),
    .single_ended_sync_in(se_in), .timestamp_diff_in(ts_in), .sysref_in(sr_in),
    .chan_a_freq_word(chan_a_freq_word), .chan_b_freq_word(chan_b_freq_word),
    .chan_a_phase_offset(chan_a_phase_offset), .chan_b_phase_offset(chan_b_phase_offset),
    .decim_mode(decim_mode), .wide_passband_by4(wide_passband_by4), .adc_data(adc_data),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .nco_a_phase(nco_a_phase),
    .nco_b_phase(nco_b_phase), .sync_armed(sync_armed), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
  ddc_link_partner ddc_link_partner_i (.sys_clk(sys_clk), .use_ts(use_timestamp_sync),
    .sync_se(se_in), .sync_ts(ts_in), .sysref(sr_in));

  // ***************************************************************
  // Checking helpers
  // ***************************************************************
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Sample handed over only at an edge where the path is ready.
  task automatic push(input logic signed [ADC_W-1:0] d);
    adc_data = d;
    adc_valid = 1'b1;
    do @(negedge sys_clk); while (adc_ready !== 1'b1);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic note(input logic cplx, input logic full, input logic signed [OUT_W-1:0] val);
    e.cplx = cplx;
    e.smp.i = val;
    e.smp.q = '0;
    exp_q.push_back(e);
    full_q.push_back(full);
  endtask
  task automatic drain();
    adc_valid = 1'b0;
    hold_off = 1'b0;
    for (int t = 0; t < 300 && exp_q.size() != 0; t++) tick(1);
    tick(8);
    chk(exp_q.size() == 0, "output count short");
  endtask
  task automatic nco_is(input logic [PHASE_W-1:0] a, input logic [PHASE_W-1:0] b, string m);
    chk(nco_a_phase === {a, 16'h0000} && nco_b_phase === {b, 16'h0000}, m);
  endtask

  // ***************************************************************
  // Output monitor: each delivered sample retires the oldest note.
  // ***************************************************************
  always @(posedge sys_clk) begin
    if (rst_n && clk_en && out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) chk(1'b0, "sample with no note");
      else begin
        e = exp_q.pop_front();
        f = full_q.pop_front();
        chk(out_data.cplx === e.cplx && (e.cplx || out_data.smp.q === '0)
            && (!f || out_data.smp.i === e.smp.i), "sample format or value");
      end
    end
  end

  initial begin
    #200_000;
    err_total++;
    print_verdict();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    tick(2);
    rst_n = 1'b1;
    chk(nco_a_phase === '0 && sync_armed === 1'b0 && out_valid === 1'b0, "reset values");
    for (int m = 0; m < 6; m++) begin
      decim_mode = modes[m];
      wide_passband_by4 = (m == 3);
      rnd_on = 1'b1;
      for (int k = 0; k < 32; k++) begin
        push(ADC_W'($random(seed)));
        // The by-2 stage weighs the last three samples 1, c, 1 around its center tap.
        fsum = (OUT_W+5)'(adc_data) + CENTER_NARROW * (OUT_W+5)'(h1) + (OUT_W+5)'(h2);
        h2 = h1;
        h1 = adc_data;
        v = (m == 1) ? OUT_W'(fsum >>> SHIFT_NARROW) : OUT_W'(adc_data);
        if ((k + 1) % fac[m] == 0) note(fac[m] > 2, m < 2, v);
      end
      drain();
    end
    rnd_on = 1'b0;
    decim_mode = DEC_NONE;
    hold_off = 1'b1;
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      push(ADC_W'($random(seed)));
      note(1'b0, 1'b1, OUT_W'(adc_data));
    end
    chk(adc_ready === 1'b0, "full buffer still ready");
    drain();
    // Phase accumulation and freeze.
    chan_a_freq_word = $random(seed);
    chan_b_freq_word = $random(seed);
    tick(2);
    p0 = nco_a_phase;
    tick(1);
    chk(nco_a_phase - p0 === chan_a_freq_word, "accumulator step");
    clk_en = 1'b0;
    p1 = nco_b_phase;
    tick(3);
    chk(nco_b_phase === p1, "frozen accumulator moved");
    clk_en = 1'b1;
    chan_a_freq_word = '0;
    chan_b_freq_word = '0;
    // Link-init sync on each SYNC pin, then refused rises with the bit or the link enable clear.
    for (int s = 0; s < 4; s++) begin
      use_timestamp_sync = s[0];
      sync_on_link_init = (s != 2);
      serial_link_enable = 1'b0;
      tick(4);
      p0 = nco_a_phase;
      p1 = nco_b_phase;
      chan_a_phase_offset = PHASE_W'($random(seed));
      chan_b_phase_offset = PHASE_W'($random(seed));
      ddc_link_partner_i.set_sync(1'b1);
      tick(1);
      serial_link_enable = (s != 3);
      ddc_link_partner_i.set_sync(1'b0);
      tick(5);
      chk(nco_a_phase === p0 && nco_b_phase === p1, "early sync");
      ddc_link_partner_i.set_sync(1'b1);
      tick(6);
      if (s < 2) nco_is(chan_a_phase_offset, chan_b_phase_offset, "link sync");
      else chk(nco_a_phase === p0, "sync with link-init or link enable clear");
    end
    sync_on_link_init = 1'b0;
    serial_link_enable = 1'b1;
    // SYSREF sync: unarmed pulse ignored, then arm and sync once.
    chan_a_phase_offset = PHASE_W'($random(seed));
    ddc_link_partner_i.pulse_sysref(3);
    tick(6);
    chk(nco_a_phase === p0, "unarmed sysref sync");
    tick(1);
    sync_on_next_sysref = 1'b1;
    tick(2);
    chk(sync_armed === 1'b1, "not armed");
    ddc_link_partner_i.pulse_sysref(3);
    tick(6);
    nco_is(chan_a_phase_offset, chan_b_phase_offset, "sysref sync");
    chk(sync_armed === 1'b0, "still armed");
    print_verdict();
  end
endmodule
